// *** hw/ctr_defines.svh ***
// Purpose: Constants for the current-trip regulator and diagnostic decode
// Assumes: 10 MHz clock
// Notes: Offsets are byte addresses on the register bus
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH
`define CTR_CLK_NS 100
`define CTR_OFF_HW_US 30
`define CTR_OFF_US0 20
`define CTR_OFF_US1 30
`define CTR_OFF_US2 40
`define CTR_OFF_US3 50
`define CTR_US2CYC(us) (((us) * 1000) / `CTR_CLK_NS)
`define CTR_BLANK_NS 2000
`define CTR_BLANK_CYC ((`CTR_BLANK_NS + `CTR_CLK_NS - 1) / `CTR_CLK_NS)
`define CTR_ADDR_CFG2 4'h0
`define CTR_ADDR_CFG3 4'h4
`define CTR_ADDR_STAT 4'h8
`define CTR_ADDR_CMD 4'hc
`define CTR_DIAGNOSTIC_SELECT_MSB 1
`define CTR_TRIP_MSB 2
`define CTR_OFF_TIME_LSB 4
`define CTR_OFF_TIME_MSB 5
`define CTR_FLAG_BIT 0
`define CTR_BUSY_BIT 1
`define CTR_CLR_BIT 0
`define CTR_DIAGNOSTIC_SELECT_RST 2'h0
`define CTR_TRIP_RST 3'h0
`define CTR_OFF_TIME_RST 2'h1
`define CTR_RESP_OK 2'h0
`define CTR_RESP_ERR 2'h2
`endif

// *** hw/ctr_pkg.sv ***
// Purpose: Types for the current-trip regulator
// Assumes: Nothing beyond the defines header
// Notes: Counter width covers the longest off-time
package ctr_pkg;
  typedef enum logic {CTR_IDLE, CTR_RECIRC} ctr_state_e;
  typedef logic [2:0] ctr_level_t;
  typedef logic [9:0] ctr_cnt_t;
endpackage

// *** hw/ctr_regulator.sv ***
// Purpose: Fixed-off-time current-trip regulation and diagnostic-select decode
// Assumes: Inputs synchronous to clk; AXI4-Lite register slave
// Notes: Level pins encode levels one to six as 0 to 5
`timescale 1ns/1ps
`include "ctr_defines.svh"
module ctr_regulator
  import ctr_pkg::*;
#(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int BLANK_CYC = `CTR_BLANK_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_one,
  input wire logic in_two,
  input wire logic driver_disable,
  input wire logic mode_indep,
  input wire logic active_state,
  input wire logic trip_cmp,
  input wire logic slewing,
  input wire logic ls_recirc,
  input wire logic [2:0] trip_level_pin,
  input wire logic [2:0] diagnostic_select_level_pin,
  output logic bridge_output_one_q,
  output logic bridge_output_two_q,
  output logic bridge_hiz_q,
  output logic recirc_q,
  output logic [2:0] trip_ref_sel_q,
  output logic off_state_load_check_q,
  output logic active_open_load_mask_q,
  output logic fault_retry_q
);
  if (BLANK_CYC < 2 || BLANK_CYC > 1023) $error("BLANK_CYC out of range");

  ctr_state_e state_q, state_d;
  ctr_cnt_t cnt_q, blank_q;
  logic [1:0] diagnostic_select_q, hi_mask_q;
  logic [2:0] trip_q, prev_q, diagnostic_select_pin_q;
  logic [1:0] off_time_q;
  logic flag_q, diagnostic_select_done_q, ls_prev_q;
  logic aw_have_q, w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  function automatic ctr_cnt_t off_len(input logic serial, input logic [1:0] sel);
    if (!serial)
      return ctr_cnt_t'(`CTR_US2CYC(`CTR_OFF_HW_US));
    unique case (sel)
      2'h0: return ctr_cnt_t'(`CTR_US2CYC(`CTR_OFF_US0));
      2'h1: return ctr_cnt_t'(`CTR_US2CYC(`CTR_OFF_US1));
      2'h2: return ctr_cnt_t'(`CTR_US2CYC(`CTR_OFF_US2));
      2'h3: return ctr_cnt_t'(`CTR_US2CYC(`CTR_OFF_US3));
    endcase
  endfunction

  // Six pin levels reach only six of the eight codes
  function automatic ctr_level_t pin_code(input logic [2:0] lvl);
    unique case (lvl)
      3'h0: return 3'h0;
      3'h1: return 3'h1;
      3'h2: return 3'h4;
      3'h3: return 3'h5;
      3'h4: return 3'h6;
      default: return 3'h7;
    endcase
  endfunction

  // Returns {off-state checks, high-side load, retry}
  function automatic logic [2:0] hw_diagnostic_select(input logic indep, input logic [2:0] lvl);
    if (!indep)
    begin
      unique case (lvl)
        3'h0: return 3'b001;
        3'h4: return 3'b000;
        default: return 3'b100;
      endcase
    end
    unique case (lvl)
      3'h0: return 3'b001;
      3'h1: return 3'b100;
      3'h2: return 3'b110;
      3'h3: return 3'b111;
      3'h4: return 3'b000;
      default: return 3'b101;
    endcase
  endfunction

  ctr_level_t level;
  logic [2:0] diagnostic_select_dec;
  logic hs_load, hs_on, reg_en, fell_ls, trip_ok, trip_now, in_chg;
  logic cmd_one, cmd_two, force_one, force_two;

  always_comb
  begin
    level = SERIAL_VARIANT ? trip_q : pin_code(trip_level_pin);
    if (SERIAL_VARIANT)
      diagnostic_select_dec = mode_indep ? {diagnostic_select_q[0], diagnostic_select_q[1], 1'b0}
                            : {diagnostic_select_q != 2'h0, 2'b00};
    else
      diagnostic_select_dec = hw_diagnostic_select(mode_indep, diagnostic_select_pin_q);
    hs_load = mode_indep & diagnostic_select_dec[1];
  end

  // PHASE_ENABLE_MODE: in_one enables, in_two gives direction
  assign cmd_one = !driver_disable & (mode_indep ? in_one : in_one & in_two);
  assign cmd_two = !driver_disable & (mode_indep ? in_two : in_one & !in_two);
  // Sense sees the sum of both high sides, so one trip serves both halves
  assign hs_on = cmd_one | cmd_two;
  assign reg_en = active_state & hs_on & (level != 3'h0) & !hs_load;
  assign fell_ls = ls_prev_q & !ls_recirc;
  assign trip_now = trip_cmp & !slewing;
  assign trip_ok = trip_now & (blank_q == '0) & !fell_ls;
  assign in_chg = {in_one, in_two, driver_disable} != prev_q;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CTR_IDLE:
        if (reg_en && trip_ok)
          state_d = CTR_RECIRC;
      CTR_RECIRC:
        if (in_chg)
          state_d = CTR_IDLE;
        else if (cnt_q == '0 && !trip_now)
          state_d = CTR_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= CTR_IDLE;
    else
      state_q <= state_d;
  end

  // Off-time counter reloads on entry and on each extension
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (state_q == CTR_IDLE || cnt_q == '0)
      cnt_q <= off_len(SERIAL_VARIANT, off_time_q) - ctr_cnt_t'(1);
    else
      cnt_q <= cnt_q - ctr_cnt_t'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      blank_q <= '0;
    else if (fell_ls)
      blank_q <= ctr_cnt_t'(BLANK_CYC);
    else if (blank_q != '0)
      blank_q <= blank_q - ctr_cnt_t'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= 3'h0;
      ls_prev_q <= 1'b0;
      hi_mask_q <= 2'h0;
    end
    else
    begin
      prev_q <= {in_one, in_two, driver_disable};
      ls_prev_q <= ls_recirc;
      if (state_q == CTR_IDLE)
        hi_mask_q <= {cmd_one, cmd_two};
    end
  end

  always_comb
  begin
    if (!mode_indep)
    begin
      force_one = 1'b1;
      force_two = 1'b1;
    end
    else
    begin
      force_one = cmd_one & !hi_mask_q[1];
      force_two = cmd_two & !hi_mask_q[0];
      if (state_q == CTR_IDLE)
      begin
        force_one = 1'b0;
        force_two = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bridge_output_one_q <= 1'b0;
      bridge_output_two_q <= 1'b0;
      bridge_hiz_q <= 1'b1;
      recirc_q <= 1'b0;
    end
    else
    begin
      bridge_output_one_q <= (state_d == CTR_RECIRC) ? force_one : cmd_one;
      bridge_output_two_q <= (state_d == CTR_RECIRC) ? force_two : cmd_two;
      bridge_hiz_q <= driver_disable;
      recirc_q <= state_d == CTR_RECIRC;
    end
  end

  // Strap caught on the first clock after reset release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      diagnostic_select_done_q <= 1'b0;
      diagnostic_select_pin_q <= 3'h0;
    end
    else if (!diagnostic_select_done_q)
    begin
      diagnostic_select_done_q <= 1'b1;
      diagnostic_select_pin_q <= diagnostic_select_level_pin;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trip_ref_sel_q <= 3'h0;
      off_state_load_check_q <= 1'b0;
      active_open_load_mask_q <= 1'b0;
      fault_retry_q <= 1'b0;
    end
    else
    begin
      trip_ref_sel_q <= level;
      off_state_load_check_q <= diagnostic_select_dec[2];
      active_open_load_mask_q <= SERIAL_VARIANT & mode_indep & !diagnostic_select_dec[1];
      fault_retry_q <= diagnostic_select_dec[0];
    end
  end

  // Register slave: address and data taken in either order
  logic do_wr, clr_cmd, trip_set;
  assign do_wr = aw_have_q & w_have_q & !s_axi_bvalid;
  assign clr_cmd = do_wr & (aw_addr_q == `CTR_ADDR_CMD) & w_strb_q[0] & w_data_q[`CTR_CLR_BIT];
  assign trip_set = SERIAL_VARIANT & reg_en & trip_ok;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTR_RESP_OK;
    end
    else
    begin
      s_axi_awready <= !aw_have_q & !(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= !w_have_q & !(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q[1:0] == 2'h0) ? `CTR_RESP_OK : `CTR_RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      diagnostic_select_q <= `CTR_DIAGNOSTIC_SELECT_RST;
      trip_q <= `CTR_TRIP_RST;
      off_time_q <= `CTR_OFF_TIME_RST;
    end
    else if (do_wr && w_strb_q[0])
    begin
      if (aw_addr_q == `CTR_ADDR_CFG2)
        diagnostic_select_q <= w_data_q[`CTR_DIAGNOSTIC_SELECT_MSB:0];
      if (aw_addr_q == `CTR_ADDR_CFG3)
      begin
        trip_q <= w_data_q[`CTR_TRIP_MSB:0];
        off_time_q <= w_data_q[`CTR_OFF_TIME_MSB:`CTR_OFF_TIME_LSB];
      end
    end
  end

  // Set wins over a clear in the same cycle; no fault pin is involved
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (trip_set)
      flag_q <= 1'b1;
    else if (clr_cmd)
      flag_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CTR_RESP_OK;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid & !(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CTR_RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        unique case (s_axi_araddr)
          `CTR_ADDR_CFG2: s_axi_rdata[`CTR_DIAGNOSTIC_SELECT_MSB:0] <= diagnostic_select_q;
          `CTR_ADDR_CFG3: s_axi_rdata[`CTR_OFF_TIME_MSB:0] <= {off_time_q, 1'b0, trip_q};
          `CTR_ADDR_STAT: s_axi_rdata[`CTR_BUSY_BIT:0] <= {recirc_q, flag_q};
          `CTR_ADDR_CMD: s_axi_rdata <= 32'h0000_0000;
          default: s_axi_rresp <= `CTR_RESP_ERR;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  sequence s_trip_end;
    state_q == CTR_RECIRC && cnt_q == '0 && !in_chg;
  endsequence

  property p_hold;
    @(posedge clk) disable iff (rst)
      state_q == CTR_RECIRC && cnt_q != '0 && !in_chg |=> state_q == CTR_RECIRC;
  endproperty
  a_hold: assert property (p_hold) else $error("off-time ended early");

  property p_extend;
    @(posedge clk) disable iff (rst)
      s_trip_end ##0 trip_now |=> state_q == CTR_RECIRC && cnt_q == $past(off_len(SERIAL_VARIANT, off_time_q)) - ctr_cnt_t'(1);
  endproperty
  a_extend: assert property (p_extend) else $error("no extension");

  property p_release;
    @(posedge clk) disable iff (rst)
      s_trip_end ##0 !trip_now |=> state_q == CTR_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("recirc not released");

  property p_override;
    @(posedge clk) disable iff (rst)
      state_q == CTR_RECIRC && in_chg |=> state_q == CTR_IDLE
        && bridge_output_one_q == $past(cmd_one) && bridge_output_two_q == $past(cmd_two);
  endproperty
  a_override: assert property (p_override) else $error("inputs not followed");

  property p_full_force;
    @(posedge clk) disable iff (rst)
      recirc_q && !mode_indep && !$past(mode_indep) |-> bridge_output_one_q && bridge_output_two_q;
  endproperty
  a_full_force: assert property (p_full_force) else $error("full bridge not high");

  property p_gate;
    @(posedge clk) disable iff (rst)
      state_q == CTR_IDLE && (!reg_en || slewing) |=> state_q == CTR_IDLE;
  endproperty
  a_gate: assert property (p_gate) else $error("trip acted while gated");

  property p_blank;
    @(posedge clk) disable iff (rst)
      fell_ls && state_q == CTR_IDLE |=> (state_q == CTR_IDLE)[*2];
  endproperty
  a_blank: assert property (p_blank) else $error("blanking skipped");

  property p_flag;
    @(posedge clk) disable iff (rst)
      trip_set || (flag_q && !clr_cmd) |=> flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("trip flag lost");

  property p_diagnostic_select_fixed;
    @(posedge clk) disable iff (rst)
      !SERIAL_VARIANT && diagnostic_select_done_q |=> $stable(diagnostic_select_pin_q);
  endproperty
  a_diagnostic_select_fixed: assert property (p_diagnostic_select_fixed) else $error("diagnostic_select pin resampled");
endmodule

// *** testbench/ctr_load_model.sv ***
// Purpose: Inductive bridge load and trip comparator facing the regulator
// Assumes: One clock; current moves one count per clock
// Notes: hold_high pins the comparator high to force extensions
`timescale 1ns/1ps
module ctr_load_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic out_one,
  input wire logic out_two,
  input wire logic hold_high,
  output logic trip_cmp,
  output logic slewing
);
  logic [7:0] cur_q;
  logic [1:0] slew_q;
  logic [1:0] outs_q;
  // Sense is the sum of both halves; current builds only while exactly one half is driven
  always_ff @(posedge clk)
  begin
    if (rst)
      cur_q <= 8'h00;
    else if ((out_one ^ out_two) && cur_q != 8'hff)
      cur_q <= cur_q + 8'h01;
    else if (!(out_one ^ out_two) && cur_q != 8'h00)
      cur_q <= cur_q - 8'h01;
  end
  always_ff @(posedge clk)
  begin
    outs_q <= {out_one, out_two};
    if (rst)
      slew_q <= 2'h0;
    else if ({out_one, out_two} != outs_q)
      slew_q <= 2'h3;
    else if (slew_q != 2'h0)
      slew_q <= slew_q - 2'h1;
  end
  assign slewing = slew_q != 2'h0;
  assign trip_cmp = hold_high || cur_q > 8'h28;
endmodule

// *** testbench/ctr_regulator_tb_top.sv ***
// Purpose: Self-checking bench for the current-trip regulator
// Assumes: 10 MHz clock, short blanking, fixed seed
// Notes: A hardwired instance covers the level pins
`timescale 1ns/1ps
`include "ctr_defines.svh"
module ctr_regulator_tb_top import ctr_pkg::*;;
  logic clk, rst, rst_hw, hold_high, ls_recirc;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic in_one, in_two, driver_disable, mode_indep, active_state, trip_cmp, slewing;
  logic [2:0] trip_level_pin, diagnostic_select_level_pin, trip_ref_sel_q, hw_trip, rc;
  logic bridge_output_one_q, bridge_output_two_q, bridge_hiz_q, recirc_q;
  logic off_state_load_check_q, active_open_load_mask_q, fault_retry_q, hw_chk, hw_retry;
  logic prev_rec, prev_slew;
  int failures, compares, seed, n;

  ctr_regulator #(.SERIAL_VARIANT(1'b1), .BLANK_CYC(2)) DUT (.clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_one, .in_two,
    .driver_disable, .mode_indep, .active_state, .trip_cmp, .slewing, .ls_recirc,
    .trip_level_pin, .diagnostic_select_level_pin, .bridge_output_one_q, .bridge_output_two_q,
    .bridge_hiz_q, .recirc_q, .trip_ref_sel_q, .off_state_load_check_q,
    .active_open_load_mask_q, .fault_retry_q);
  // Write channel of the hardwired instance stays idle; it only decodes the level pins
  ctr_regulator #(.SERIAL_VARIANT(1'b0), .BLANK_CYC(2)) dut_hw (.clk, .rst(rst_hw),
    .s_axi_awaddr, .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .in_one, .in_two,
    .driver_disable, .mode_indep, .active_state, .trip_cmp, .slewing, .ls_recirc,
    .trip_level_pin, .diagnostic_select_level_pin, .bridge_output_one_q(), .bridge_output_two_q(),
    .bridge_hiz_q(), .recirc_q(), .trip_ref_sel_q(hw_trip), .off_state_load_check_q(hw_chk),
    .active_open_load_mask_q(), .fault_retry_q(hw_retry));
  ctr_load_model load (.clk, .rst, .out_one(bridge_output_one_q),
    .out_two(bridge_output_two_q), .hold_high, .trip_cmp, .slewing);

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  task automatic wait_rec();
    n = 0;
    while (!recirc_q && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Measures one off-time; hold_high keeps the comparator up until cycle k
  task automatic run_off(input logic h, input int k, input int exp);
    wait_rec();
    hold_high <= h;
    chk({bridge_output_one_q, bridge_output_two_q}, 2'b11);
    n = 0;
    while (recirc_q && n < 2000)
    begin
      @(posedge clk);
      n++;
      if (n == k) hold_high <= 1'b0;
    end
    chk(n, exp);
  endtask

  task automatic diagnostic_select_loop();
    driver_disable <= 1'b1;
    in_one <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(`CTR_ADDR_CFG2, c, 2'b00);
      rdc(`CTR_ADDR_CFG2, c, 2'b00);
      active_state <= 1'b1;
      repeat (3) @(posedge clk);
      chk(active_open_load_mask_q, mode_indep & !c[1]);
      active_state <= 1'b0;
      repeat (3) @(posedge clk);
      chk(off_state_load_check_q, mode_indep ? c[0] : c != 0);
    end
    for (int l = 0; l < 6; l++)
    begin
      diagnostic_select_level_pin <= l[2:0];
      trip_level_pin <= l[2:0];
      rst_hw <= 1'b1;
      repeat (2) @(posedge clk);
      rst_hw <= 1'b0;
      repeat (3) @(posedge clk);
      diagnostic_select_level_pin <= 3'((l + 3) % 6);
      repeat (3) @(posedge clk);
      chk(hw_chk, l != 0 && l != 4);
      chk(hw_retry, mode_indep ? (l == 0 || l == 3 || l == 5) : l == 0);
      chk(hw_trip, l < 2 ? l : l + 2);
    end
    chk(bridge_hiz_q, 1'b1);
    driver_disable <= 1'b0;
    active_state <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (!rst && recirc_q && !prev_rec) chk(prev_slew, 1'b0);
    prev_rec <= recirc_q;
    prev_slew <= slewing;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial
  begin
    {clk, rst, rst_hw, hold_high, ls_recirc, prev_rec, prev_slew} = 7'h30;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {12'h00f, 32'h0000_0000};
    {in_one, in_two, driver_disable, mode_indep, active_state} = 5'h01;
    {trip_level_pin, diagnostic_select_level_pin} = 6'h00;
    {failures, compares, seed} = {32'h0, 32'h0, 32'd42526};
    repeat (6) @(posedge clk);
    chk(bridge_hiz_q, 1'b1);
    rst <= 1'b0;
    rst_hw <= 1'b0;
    rdc(`CTR_ADDR_CFG3, 32'h0000_0010, 2'b00);
    rdc(4'h2, 32'h0000_0000, 2'b10);
    wr(4'h6, 32'h0000_0017, 2'b10);
    rdc(`CTR_ADDR_CFG3, 32'h0000_0010, 2'b00);
    for (int c = 0; c < 8; c++)
    begin
      wr(`CTR_ADDR_CFG3, c, 2'b00);
      @(posedge clk);
      chk(trip_ref_sel_q, c);
    end
    rc = 3'($random(seed)) | 3'h1;
    wr(`CTR_ADDR_CFG3, {29'h0, rc}, 2'b00);
    @(posedge clk);
    chk(trip_ref_sel_q, rc);
    {in_one, in_two, hold_high, ls_recirc} <= 4'h7;
    repeat (50) @(posedge clk);
    chk(recirc_q, 1'b0);
    {hold_high, ls_recirc} <= 2'h0;
    diagnostic_select_loop();
    wr(`CTR_ADDR_CFG2, 32'h0000_0000, 2'b00);
    {in_one, in_two} <= 2'h3;
    run_off(1'b0, 0, 200);
    run_off(1'b1, 210 + ($random(seed) & 127), 400);
    rdc(`CTR_ADDR_STAT, 32'h0000_0001, 2'b00);
    wait_rec();
    in_two <= 1'b0;
    repeat (2) @(posedge clk);
    chk({recirc_q, bridge_output_one_q, bridge_output_two_q}, 3'b001);
    in_one <= 1'b0;
    repeat (5) @(posedge clk);
    wr(`CTR_ADDR_CMD, 32'h0000_0001, 2'b00);
    rdc(`CTR_ADDR_STAT, 32'h0000_0000, 2'b00);
    {mode_indep, rst} <= 2'h3;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(`CTR_ADDR_CFG3, {29'h0, rc}, 2'b00);
    {in_one, in_two} <= 2'h2;
    wait_rec();
    chk({bridge_output_one_q, bridge_output_two_q}, 2'b00);
    in_one <= 1'b0;
    wr(`CTR_ADDR_CFG2, 32'h0000_0002, 2'b00);
    {in_one, hold_high} <= 2'h3;
    repeat (300) @(posedge clk);
    chk(recirc_q, 1'b0);
    hold_high <= 1'b0;
    diagnostic_select_loop();
    print_verdict();
  end
endmodule
